// ### logic/irq_flag_pkg.sv
// constants shared by the peripheral interrupt flag bank
// assumes a byte-addressed slave with one 32-bit word per register
package irq_flag_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_FLAGS_TWO    = 6'h00;
  localparam logic [5:0] OFS_FLAGS_THREE  = 6'h04;
  localparam logic [5:0] OFS_FLAGS_FOUR   = 6'h08;
  localparam logic [5:0] OFS_FLAGS_FIVE   = 6'h0C;
  localparam logic [5:0] OFS_FLAGS_SIX    = 6'h10;
  localparam logic [5:0] OFS_ENABLES_TWO  = 6'h14;
  localparam logic [5:0] OFS_ENABLES_SIX  = 6'h24;
  localparam logic [5:0] OFS_CONTROL      = 6'h28;
  localparam logic [5:0] OFS_STATUS       = 6'h2C;

  // ---------------------------------------------------------------
  // implemented bits per register, full and small memory variants
  // ---------------------------------------------------------------
  localparam logic [7:0] IMPL_TWO         = 8'hBF;
  localparam logic [7:0] IMPL_THREE       = 8'hFF;
  localparam logic [7:0] IMPL_FOUR_FULL   = 8'hFF;
  localparam logic [7:0] IMPL_FOUR_SMALL  = 8'h3F;
  localparam logic [7:0] IMPL_FIVE_FULL   = 8'hFF;
  localparam logic [7:0] IMPL_FIVE_SMALL  = 8'h17;
  localparam logic [7:0] IMPL_SIX         = 8'h17;
  // bits that software cannot write (receive full, transmit empty)
  localparam logic [7:0] RO_THREE         = 8'h30;
  localparam logic [7:0] RO_NONE          = 8'h00;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [7:0]  ENABLES_RESET   = 8'h00;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // control and status field positions
  // ---------------------------------------------------------------
  localparam int CTRL_PRIO_BIT            = 0;
  localparam int CTRL_GLOBAL_BIT          = 1;
  localparam int STAT_PENDING_BIT         = 0;

  // ---------------------------------------------------------------
  // flag bit positions that carry special behaviour
  // ---------------------------------------------------------------
  localparam int BIT_DISPLAY_DONE         = 6;
  localparam int BIT_RX_FULL              = 5;
  localparam int BIT_TX_EMPTY             = 4;

  // capture/compare unit operating modes
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_PWM
  } capcmp_mode_t;

endpackage : irq_flag_pkg

// ### logic/flag_bank_if.sv
// bundle between the flag bank top and one eight-bit flag store
// assumes one owner drives set, clear and write; the store drives value
`timescale 1ns/100ps
interface flag_bank_if;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;

  modport owner (output set_bits, output clr_bits, output wr_en,
                 output wr_data, input value);
  modport store (input set_bits, input clr_bits, input wr_en,
                 input wr_data, output value);
endinterface : flag_bank_if

// ### logic/flag_store.sv
// one eight-bit sticky flag register with per-bit hardware set and clear
// assumes set and clear are one-cycle pulses in the system clock domain
`timescale 1ns/100ps
module flag_store #(
  parameter logic [7:0] IMPL = 8'hFF,
  parameter logic [7:0] RO   = 8'h00
) (
  // clock and control
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      clk_en,
  // flag traffic
  flag_bank_if.store     bank
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // software write, then hardware clear, then hardware set on top
  always_comb begin
    flags_nxt = flags_r;
    if (bank.wr_en) begin
      flags_nxt = (bank.wr_data & ~RO) | (flags_r & RO);
    end
    flags_nxt = flags_nxt & ~bank.clr_bits;
    flags_nxt = (flags_nxt | bank.set_bits) & IMPL; // set wins
  end

  // sticky storage, cleared at reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= irq_flag_pkg::FLAGS_RESET;
    end else if (clk_en) begin
      flags_r <= flags_nxt;
    end
  end

  assign bank.value = flags_r;

endmodule : flag_store

// ### logic/periph_irq_flag_bank.sv
// peripheral interrupt flag registers two to six with enables and request
// assumes all event inputs are one-cycle pulses synchronous to SYS_CLK
`timescale 1ns/100ps
module periph_irq_flag_bank #(
  parameter bit FULL_MEMORY = 1'b1
) (
  // clock, reset, enable
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        CLK_EN,
  // avalon-mm slave
  input  wire logic [5:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [3:0]  BYTEENABLE,
  input  wire logic [31:0] WRITEDATA,
  output logic [31:0]      READDATA,
  output logic             WAITREQUEST,
  // clock, serial and supply events
  input  wire logic        OSC_FAIL,
  input  wire logic        SYNC_PORT2_DONE,
  input  wire logic        COLLISION1,
  input  wire logic        COLLISION2,
  input  wire logic        VOLTAGE_DETECT,
  // timer events
  input  wire logic        TIMER3_OVERFLOW,
  input  wire logic        TIMER3_GATE,
  input  wire logic        TIMER5_GATE,
  input  wire logic        TIMER5_OVERFLOW,
  input  wire logic        TIMER7_GATE,
  input  wire logic        TIMER7_OVERFLOW,
  input  wire logic [4:0]  TIMER_MATCH,
  // display events and mode
  input  wire logic        DISPLAY_FRAME_DONE,
  input  wire logic        DISPLAY_TYPE_B,
  input  wire logic        DISPLAY_NONSTATIC,
  // second serial buffer events
  input  wire logic        SERIAL2_RX_LOAD,
  input  wire logic        SERIAL2_RX_READ,
  input  wire logic        SERIAL2_TX_DRAIN,
  input  wire logic        SERIAL2_TX_WRITE,
  // other units
  input  wire logic        CHARGE_UNIT_EVENT,
  input  wire logic        RTC_EVENT,
  input  wire logic        NV_WRITE_DONE,
  input  wire logic [2:0]  COMPARATOR_EVENT,
  // capture/compare units one to ten
  input  wire logic [9:0]  CAPCMP_CAPTURE,
  input  wire logic [9:0]  CAPCMP_MATCH,
  input  wire logic [19:0] CAPCMP_MODE,
  // request to the core
  output logic             PERIPH_IRQ
);

  // flag registers two to six; register one lives elsewhere
  localparam int NREG = 5;

  // ---------------------------------------------------------------
  // implemented bit masks for this variant
  // missing bits are masked, so stores and enables never hold them
  // ---------------------------------------------------------------
  localparam logic [7:0] IMPL_FOUR = FULL_MEMORY ?
    irq_flag_pkg::IMPL_FOUR_FULL : irq_flag_pkg::IMPL_FOUR_SMALL;
  localparam logic [7:0] IMPL_FIVE = FULL_MEMORY ?
    irq_flag_pkg::IMPL_FIVE_FULL : irq_flag_pkg::IMPL_FIVE_SMALL;
  localparam logic [7:0] IMPL [NREG] = '{irq_flag_pkg::IMPL_TWO,
                                         irq_flag_pkg::IMPL_THREE,
                                         IMPL_FOUR,
                                         IMPL_FIVE,
                                         irq_flag_pkg::IMPL_SIX};

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]  set_v [NREG];
  logic [7:0]  clr_v [NREG];
  logic [7:0]  wr_v  [NREG];
  logic [7:0]  flags [NREG];
  logic [7:0]  en_r  [NREG];
  logic [9:0]  capcmp_hit;
  logic        prio_en_r;
  logic        global_en_r;
  logic        pending;
  logic        req_take;
  logic        wr_go;
  logic [31:0] rdata_nxt;
  logic [5:0]  addr_word;
  logic        display_valid;
  logic        gate_open;

  // the two low address bits pick a byte and are ignored
  assign addr_word = {ADDRESS[5:2], 2'b00};

  // ---------------------------------------------------------------
  // event qualification
  // ---------------------------------------------------------------

  // capture counts only in capture mode, match only in compare mode;
  // pulse-width and off modes never raise the flag; the mode is
  // taken with the event, so a change of mode acts at once
  always_comb begin
    for (int u = 0; u < 10; u++) begin
      case (irq_flag_pkg::capcmp_mode_t'(CAPCMP_MODE[2*u +: 2]))
        irq_flag_pkg::MODE_CAPTURE: capcmp_hit[u] = CAPCMP_CAPTURE[u];
        irq_flag_pkg::MODE_COMPARE: capcmp_hit[u] = CAPCMP_MATCH[u];
        default:                    capcmp_hit[u] = 1'b0;
      endcase
    end
  end

  // the display flag means nothing outside type-B non-static drive,
  // so the pulse is dropped rather than left for software to mask
  assign display_valid = DISPLAY_TYPE_B & DISPLAY_NONSTATIC;

  // ---------------------------------------------------------------
  // set vectors, independent of any enable
  // ---------------------------------------------------------------
  // each vector runs bit 7 down to bit 0; an event held high keeps
  // setting its flag, so a clear written meanwhile is lost
  always_comb begin
    set_v[0] = {OSC_FAIL,
                1'b0,
                SYNC_PORT2_DONE,
                COLLISION2, COLLISION1,
                VOLTAGE_DETECT,
                TIMER3_OVERFLOW, TIMER3_GATE};
    set_v[1] = {TIMER5_GATE,
                DISPLAY_FRAME_DONE & display_valid,
                SERIAL2_RX_LOAD,
                SERIAL2_TX_DRAIN,
                CHARGE_UNIT_EVENT,
                capcmp_hit[1], capcmp_hit[0],
                RTC_EVENT};
    set_v[2] = capcmp_hit[9:2];
    set_v[3] = {TIMER7_GATE,
                TIMER_MATCH[4], TIMER_MATCH[3],
                TIMER_MATCH[2],
                TIMER7_OVERFLOW,
                TIMER_MATCH[1],
                TIMER5_OVERFLOW,
                TIMER_MATCH[0]};
    set_v[4] = {3'b000,
                NV_WRITE_DONE,
                1'b0,
                COMPARATOR_EVENT};
  end

  // hardware clears: only the serial buffer flags have them;
  // a load and an access in one cycle leave the flag set, since
  // a lost set would hide a byte and a late clear costs one poll
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      clr_v[i] = 8'h00;
    end
    clr_v[1][irq_flag_pkg::BIT_RX_FULL]  = SERIAL2_RX_READ;
    clr_v[1][irq_flag_pkg::BIT_TX_EMPTY] = SERIAL2_TX_WRITE;
  end

  // ---------------------------------------------------------------
  // flag stores
  // ---------------------------------------------------------------
  // one store per register; the buffer bits of flags three are
  // read-only, so software can neither fake nor drop them
  flag_bank_if fb [NREG] ();

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_store
      assign fb[g].set_bits = set_v[g];
      assign fb[g].clr_bits = clr_v[g];
      // a write lands only at the answer edge of its own word
      assign fb[g].wr_en    = wr_go && addr_word == 6'(4 * g);
      assign fb[g].wr_data  = wr_v[g];
      assign flags[g]       = fb[g].value;

      flag_store #(
        .IMPL (IMPL[g]),
        .RO   ((g == 1) ? irq_flag_pkg::RO_THREE : irq_flag_pkg::RO_NONE)
      ) u_store (
        .clk    (SYS_CLK),
        .rst_n  (RST_N),
        .clk_en (CLK_EN),
        .bank   (fb[g])
      );
    end
  endgenerate

  // write data goes to the low byte lane only; upper lanes
  // carry no bits, so such a write is answered and does nothing
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      wr_v[i] = WRITEDATA[7:0];
    end
  end

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------

  // a request is taken on the first edge it is seen; the answer comes
  // one cycle later with waitrequest low, costing one wait state per
  // access but keeping every output straight from a flop;
  // with CLK_EN low the handshake freezes too, so a master
  // must wait for the answer rather than count cycles
  assign req_take = (READ | WRITE) & WAITREQUEST;
  assign wr_go    = WRITE & ~WAITREQUEST & BYTEENABLE[0];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WAITREQUEST <= 1'b1;
    end else if (CLK_EN) begin
      WAITREQUEST <= ~req_take;
    end
  end

  // ---------------------------------------------------------------
  // enable and control registers
  // ---------------------------------------------------------------

  // six enable groups exist; the first group belongs with flag group
  // one, which lives elsewhere, so only groups two to six are here;
  // enables of missing flags stay zero so no stale write arms them
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < NREG; i++) begin
        en_r[i] <= irq_flag_pkg::ENABLES_RESET;
      end
    end else if (CLK_EN && wr_go) begin
      for (int i = 0; i < NREG; i++) begin
        if (addr_word == irq_flag_pkg::OFS_ENABLES_TWO + 6'(4 * i)) begin
          en_r[i] <= WRITEDATA[7:0] & IMPL[i];
        end
      end
    end
  end

  // priority mode and peripheral global enable
  // both share one word so a single write changes them together
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      prio_en_r   <= 1'b0;
      global_en_r <= 1'b0;
    end else if (CLK_EN && wr_go && addr_word == irq_flag_pkg::OFS_CONTROL) begin
      prio_en_r   <= WRITEDATA[irq_flag_pkg::CTRL_PRIO_BIT];
      global_en_r <= WRITEDATA[irq_flag_pkg::CTRL_GLOBAL_BIT];
    end
  end

  // ---------------------------------------------------------------
  // request to the core
  // ---------------------------------------------------------------

  // any flag with its enable set is pending; without priority mode the
  // global enable must also be set before the request leaves
  always_comb begin
    pending = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      pending = pending | (|(flags[i] & en_r[i]));
    end
  end

  // in priority mode the priority logic past this bank gates the
  // request, so only the plain mode needs the global enable
  assign gate_open = prio_en_r | global_en_r;

  // registered for a clean level, at one cycle of latency
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PERIPH_IRQ <= 1'b0;
    end else if (CLK_EN) begin
      PERIPH_IRQ <= pending & gate_open;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------

  // decode on the taking edge; unmapped words read as zero, and a
  // full compare per flag word never indexes past the last store
  always_comb begin
    rdata_nxt = irq_flag_pkg::RDATA_RESET;
    if (addr_word == irq_flag_pkg::OFS_FLAGS_TWO) begin
      rdata_nxt[7:0] = flags[0];
    end else if (addr_word == irq_flag_pkg::OFS_FLAGS_THREE) begin
      rdata_nxt[7:0] = flags[1];
    end else if (addr_word == irq_flag_pkg::OFS_FLAGS_FOUR) begin
      rdata_nxt[7:0] = flags[2];
    end else if (addr_word == irq_flag_pkg::OFS_FLAGS_FIVE) begin
      rdata_nxt[7:0] = flags[3];
    end else if (addr_word == irq_flag_pkg::OFS_FLAGS_SIX) begin
      rdata_nxt[7:0] = flags[4];
    end else if (addr_word >= irq_flag_pkg::OFS_ENABLES_TWO &&
                 addr_word <= irq_flag_pkg::OFS_ENABLES_SIX) begin
      rdata_nxt[7:0] = en_r[3'(addr_word[5:2] - 4'h5)];
    end else if (addr_word == irq_flag_pkg::OFS_CONTROL) begin
      rdata_nxt[irq_flag_pkg::CTRL_PRIO_BIT]   = prio_en_r;
      rdata_nxt[irq_flag_pkg::CTRL_GLOBAL_BIT] = global_en_r;
    end else if (addr_word == irq_flag_pkg::OFS_STATUS) begin
      rdata_nxt[irq_flag_pkg::STAT_PENDING_BIT] = pending;
    end
  end

  // read data is held until the next taken read
  // rather than cleared, so a slow master may still sample it
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      READDATA <= irq_flag_pkg::RDATA_RESET;
    end else if (CLK_EN && req_take && READ) begin
      READDATA <= rdata_nxt;
    end
  end

  // the core keeps its own part: clearing flags before enabling and
  // after service is left to software, the bank does not enforce it

endmodule : periph_irq_flag_bank

// ### verif/flag_bank_checker.sv
// bus handshake and read-back properties of the flag bank top
// assumes one clock domain and a reset held for at least two edges
`timescale 1ns/100ps
module flag_bank_checker (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        CLK_EN,
  // register bus
  input wire logic [5:0]  ADDRESS,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  // request to the core
  input wire logic        PERIPH_IRQ
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // a taken request is answered in the very next cycle
  a_answer_next_cycle: assert property ((READ || WRITE) && WAITREQUEST && CLK_EN |=> !WAITREQUEST)
    else $error("bus answer late");
  a_answer_one_cycle: assert property (!WAITREQUEST && CLK_EN |=> WAITREQUEST)
    else $error("answer longer than one cycle");
  a_answer_has_cause: assert property ($fell(WAITREQUEST) |-> $past(READ || WRITE))
    else $error("answer without request");
  a_rdata_upper_zero: assert property (READDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_rdata_holds: assert property (!$stable(READDATA) |-> $past(READ && WAITREQUEST && CLK_EN))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (READ && WAITREQUEST && CLK_EN && ADDRESS[5:2] > 4'hB
    |=> READDATA == 32'h00000000) else $error("unmapped read not zero");
  a_two_gap_zero: assert property (READ && WAITREQUEST && CLK_EN && ADDRESS[5:2] == 4'h0
    |=> READDATA[6] == 1'b0) else $error("flags two gap bit set");
  a_six_gaps_zero: assert property (READ && WAITREQUEST && CLK_EN && ADDRESS[5:2] == 4'h4
    |=> (READDATA[7:0] & ~irq_flag_pkg::IMPL_SIX) == 8'h00) else $error("flags six gap bit set");
  a_reset_quiet: assert property ($past(!RST_N) |->
    !PERIPH_IRQ && READDATA == 32'h0 && WAITREQUEST)
    else $error("outputs not quiet after reset");

  // main scenarios reached
  cover property (READ && !WAITREQUEST);
  cover property (WRITE && !WAITREQUEST);
  cover property ($rose(PERIPH_IRQ));
endmodule : flag_bank_checker

bind periph_irq_flag_bank flag_bank_checker i_checker (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .PERIPH_IRQ(PERIPH_IRQ)
);

// ### verif/event_source_model.sv
// peripheral event sources: one-cycle pulse on the selected event line
// assumes index = register number (two..six as 0..4) * 8 + flag bit
`timescale 1ns/100ps
module event_source_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // command from the bench
  input  wire logic       fire,
  input  wire logic [5:0] sel,
  // event lines
  output logic [39:0]     ev
);
  // single pulse, since a held level would keep setting a cleared flag
  always_ff @(posedge clk) begin
    ev <= (rst_n && fire) ? (40'h1 << sel) : 40'h0;
  end
endmodule : event_source_model

// ### verif/periph_irq_flag_bank_bench.sv
// self-checking bench: event walk, random events, bus corners, request
// assumes the checker is bound to the top and events come from the model
`timescale 1ns/100ps
module periph_irq_flag_bank_bench;
  logic        sys_clk;
  logic        rst_n;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic [31:0] readdata_small;
  logic        waitrequest;
  logic        fire;
  logic [5:0]  sel;
  logic [39:0] ev;
  logic [9:0]  cap_ev;
  logic        kind;
  logic        type_b;
  logic        nonstatic;
  logic [19:0] modes;
  logic        rx_read;
  logic        tx_write;
  logic        irq;
  logic        clk_en;
  logic [7:0]  rd;
  logic [7:0]  want;
  logic [7:0]  rd_small;
  int          seed;
  int          n_errors;
  int          compares;
  int          s;

  // capture units one and two sit in flags three, three to ten in flags four
  assign cap_ev = {ev[23:16], ev[10], ev[9]};

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  event_source_model i_src (.clk(sys_clk), .rst_n(rst_n), .fire(fire), .sel(sel), .ev(ev));

  periph_irq_flag_bank i_dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(clk_en), .ADDRESS(address), .READ(read),
    .WRITE(write), .BYTEENABLE(byteenable), .WRITEDATA(writedata), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .OSC_FAIL(ev[7]), .SYNC_PORT2_DONE(ev[5]),
    .COLLISION1(ev[3]), .COLLISION2(ev[4]), .VOLTAGE_DETECT(ev[2]),
    .TIMER3_OVERFLOW(ev[1]), .TIMER3_GATE(ev[0]), .TIMER5_GATE(ev[15]),
    .TIMER5_OVERFLOW(ev[25]), .TIMER7_GATE(ev[31]), .TIMER7_OVERFLOW(ev[27]),
    .TIMER_MATCH({ev[30], ev[29], ev[28], ev[26], ev[24]}), .DISPLAY_FRAME_DONE(ev[14]),
    .DISPLAY_TYPE_B(type_b), .DISPLAY_NONSTATIC(nonstatic), .SERIAL2_RX_LOAD(ev[13]),
    .SERIAL2_RX_READ(rx_read), .SERIAL2_TX_DRAIN(ev[12]), .SERIAL2_TX_WRITE(tx_write),
    .CHARGE_UNIT_EVENT(ev[11]), .RTC_EVENT(ev[8]), .NV_WRITE_DONE(ev[36]),
    .COMPARATOR_EVENT(ev[34:32]), .CAPCMP_CAPTURE(cap_ev & {10{kind}}),
    .CAPCMP_MATCH(cap_ev & {10{~kind}}), .CAPCMP_MODE(modes), .PERIPH_IRQ(irq)
  );

  // small-memory variant on the same bus and events; its read data is checked
  periph_irq_flag_bank #(.FULL_MEMORY(1'b0)) i_dut_small (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(clk_en), .ADDRESS(address), .READ(read),
    .WRITE(write), .BYTEENABLE(byteenable), .WRITEDATA(writedata),
    .READDATA(readdata_small), .WAITREQUEST(), .OSC_FAIL(ev[7]), .SYNC_PORT2_DONE(ev[5]),
    .COLLISION1(ev[3]), .COLLISION2(ev[4]), .VOLTAGE_DETECT(ev[2]),
    .TIMER3_OVERFLOW(ev[1]), .TIMER3_GATE(ev[0]), .TIMER5_GATE(ev[15]),
    .TIMER5_OVERFLOW(ev[25]), .TIMER7_GATE(ev[31]), .TIMER7_OVERFLOW(ev[27]),
    .TIMER_MATCH({ev[30], ev[29], ev[28], ev[26], ev[24]}), .DISPLAY_FRAME_DONE(ev[14]),
    .DISPLAY_TYPE_B(type_b), .DISPLAY_NONSTATIC(nonstatic), .SERIAL2_RX_LOAD(ev[13]),
    .SERIAL2_RX_READ(rx_read), .SERIAL2_TX_DRAIN(ev[12]), .SERIAL2_TX_WRITE(tx_write),
    .CHARGE_UNIT_EVENT(ev[11]), .RTC_EVENT(ev[8]), .NV_WRITE_DONE(ev[36]),
    .COMPARATOR_EVENT(ev[34:32]), .CAPCMP_CAPTURE(cap_ev & {10{kind}}),
    .CAPCMP_MATCH(cap_ev & {10{~kind}}), .CAPCMP_MODE(modes), .PERIPH_IRQ()
  );

  // ---------------------------------------------------------------
  // expectations and bus tasks
  // ---------------------------------------------------------------
  // whether an event at index idx must leave its flag set
  function automatic logic exp_set(input int idx, input logic [19:0] m, input logic k,
                                   input logic tb, input logic ns);
    logic [39:0] impl;
    logic [1:0]  um;
    int          u;
    impl = {irq_flag_pkg::IMPL_SIX, irq_flag_pkg::IMPL_FIVE_FULL,
            irq_flag_pkg::IMPL_FOUR_FULL, irq_flag_pkg::IMPL_THREE, irq_flag_pkg::IMPL_TWO};
    u = (idx == 9) ? 0 : (idx == 10) ? 1 : (idx >= 16 && idx <= 23) ? idx - 14 : -1;
    if (!impl[idx]) return 1'b0;
    if (idx == 14) return tb && ns;
    if (u < 0) return 1'b1;
    um = m[2 * u +: 2];
    return (um == irq_flag_pkg::MODE_CAPTURE && k) || (um == irq_flag_pkg::MODE_COMPARE && !k);
  endfunction : exp_set

  task automatic check(input logic [7:0] got, input logic [7:0] exp_v);
    compares++;
    if (got !== exp_v) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp_v);
    end
  endtask : check

  // one request held until waitrequest is sampled low
  task automatic bus(input logic [5:0] a, input logic wr_n_rd, input logic [3:0] be,
                     input logic [7:0] wd, output logic [7:0] q);
    int n;
    @(posedge sys_clk);
    address    <= a;
    read       <= ~wr_n_rd;
    write      <= wr_n_rd;
    byteenable <= be;
    writedata  <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata[7:0];
    rd_small = readdata_small[7:0];
    if (waitrequest !== 1'b0) begin
      n_errors++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
    end
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(a, 1'b1, 4'hF, d, rd);
  endtask : wr

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp_v);
    bus(a, 1'b0, 4'hF, 8'h00, rd);
    check(rd, exp_v);
  endtask : rdchk

  task automatic pulse(input int idx);
    @(posedge sys_clk);
    fire <= 1'b1;
    sel  <= 6'(idx);
    @(posedge sys_clk);
    fire <= 1'b0;
    @(posedge sys_clk);
  endtask : pulse

  task automatic settle_irq(input logic [7:0] exp_v);
    repeat (2) @(posedge sys_clk);
    check(8'(irq), exp_v);
  endtask : settle_irq

  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    #(100 * 20000);
    n_errors++;
    report_and_stop();
  end

  initial begin
    seed = 58; n_errors = 0; compares = 0; rst_n = 1'b0; address = 6'h00; read = 1'b0;
    write = 1'b0; byteenable = 4'hF; writedata = 32'h0; fire = 1'b0; sel = 6'h00;
    kind = 1'b0; type_b = 1'b0; nonstatic = 1'b0; modes = 20'h0; rx_read = 1'b0;
    tx_write = 1'b0;
    clk_en = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    // flags, enables, control and status all start clear; unmapped word reads zero
    for (int w = 0; w < 12; w++) rdchk(6'(w * 4), 8'h00);
    rdchk(6'h34, 8'h00);
    wr(irq_flag_pkg::OFS_FLAGS_THREE, 8'h30);
    rdchk(irq_flag_pkg::OFS_FLAGS_THREE, 8'h00);
    // walk every event line once, then random lines with random modes
    for (int i = 0; i < 80; i++) begin
      s = (i < 40) ? i : int'($unsigned($random(seed)) % 40);
      modes     <= 20'($random(seed));
      kind      <= 1'($random(seed));
      type_b    <= (i == 14) | 1'($random(seed));
      nonstatic <= (i == 14) | 1'($random(seed));
      pulse(s);
      want = exp_set(s, modes, kind, type_b, nonstatic) ? 8'(1 << (s % 8)) : 8'h00;
      // a second read shows the flag is held, the next register stays clear
      repeat (2) rdchk(6'((s / 8) * 4), want);
      rdchk(6'(((s / 8 + 1) % 5) * 4), 8'h00);
      wr(6'((s / 8) * 4), 8'h00);
      @(posedge sys_clk);
      rx_read  <= 1'b1;
      tx_write <= 1'b1;
      @(posedge sys_clk);
      rx_read  <= 1'b0;
      tx_write <= 1'b0;
      rdchk(6'((s / 8) * 4), 8'h00);
    end
    // a clear with byte lane zero disabled is ignored
    pulse(7);
    bus(irq_flag_pkg::OFS_FLAGS_TWO, 1'b1, 4'hE, 8'h00, rd);
    rdchk(irq_flag_pkg::OFS_FLAGS_TWO, 8'h80);
    wr(irq_flag_pkg::OFS_FLAGS_TWO, 8'h00);
    // a frozen bank ignores an event that a running one would latch
    clk_en <= 1'b0;
    pulse(7);
    clk_en <= 1'b1;
    rdchk(irq_flag_pkg::OFS_FLAGS_TWO, 8'h00);
    // software may set flags by writing; the small variant lacks some bits
    wr(irq_flag_pkg::OFS_FLAGS_FOUR, 8'hFF);
    rdchk(irq_flag_pkg::OFS_FLAGS_FOUR, 8'hFF);
    check(rd_small, irq_flag_pkg::IMPL_FOUR_SMALL);
    wr(irq_flag_pkg::OFS_FLAGS_FIVE, 8'hFF);
    rdchk(irq_flag_pkg::OFS_FLAGS_FIVE, 8'hFF);
    check(rd_small, irq_flag_pkg::IMPL_FIVE_SMALL);
    // request path: flags cleared before enabling, then gated by control
    wr(irq_flag_pkg::OFS_ENABLES_TWO, 8'h08);
    pulse(3);
    settle_irq(8'h00);
    rdchk(irq_flag_pkg::OFS_STATUS, 8'h01);
    wr(irq_flag_pkg::OFS_CONTROL, 8'h02);
    settle_irq(8'h01);
    wr(irq_flag_pkg::OFS_CONTROL, 8'h01);
    settle_irq(8'h01);
    wr(irq_flag_pkg::OFS_FLAGS_TWO, 8'h00);
    settle_irq(8'h00);
    report_and_stop();
  end
endmodule : periph_irq_flag_bank_bench
